// File: hw/dma_pkg.sv
// Shared constants and types for the DMA channel transfer control block
package dma_pkg;

    localparam int NCH = 6;
    localparam int NEV = 10;
    localparam int NCPU = 4;

    // Address adjustment modes
    localparam logic [1:0] AM_CONST = 2'b00;
    localparam logic [1:0] AM_INC = 2'b01;
    localparam logic [1:0] AM_DEC = 2'b10;
    localparam logic [1:0] AM_INDEX = 2'b11;

    // Sync event select codes
    localparam logic [3:0] SYNC_NONE = 4'h0;
    localparam logic [3:0] SYNC_UART = 4'h7;
    localparam logic [3:0] SYNC_TMR0 = 4'hD;
    localparam logic [3:0] SYNC_EXT3 = 4'hE;
    localparam logic [3:0] SYNC_TMR1 = 4'hF;

    // Event input bit positions above the serial port events
    localparam int EV_UART = 6;
    localparam int EV_TMR0 = 7;
    localparam int EV_EXT3 = 8;
    localparam int EV_TMR1 = 9;

    // Interrupt line mux codes
    localparam logic [1:0] MUX_SERIAL = 2'b00;
    localparam logic [1:0] MUX_CH23 = 2'b01;
    localparam logic [1:0] MUX_ALL = 2'b10;

    // Reset values
    localparam logic [15:0] RST_ADDR = 16'h0000;
    localparam logic [15:0] RST_ELEM = 16'h0000;
    localparam logic [7:0] RST_FRAME = 8'h00;
    localparam logic [2:0] RST_PTR = 3'h5;
    localparam logic [2:0] RELOAD_SET0 = 3'h0;

    typedef struct packed {
        logic hi_prio;
        logic auto_reinit_enable;
        logic auto_buffer_mode;
        logic dword;
        logic irq_enable_bit;
        logic irq_timing_select;
        logic source_index_select;
        logic dest_index_select;
        logic [1:0] src_mode;
        logic [1:0] dst_mode;
        logic [3:0] sync_event_select;
    } chan_cfg_t;

    typedef struct packed {
        logic [15:0] src;
        logic [15:0] dst;
        logic [15:0] elem;
        logic [7:0] frame;
    } chan_load_t;

    typedef struct packed {
        logic [7:0] frame;
        logic [15:0] count;
    } reload_t;

    typedef struct packed {
        logic [15:0] src;
        logic [15:0] dst;
        logic [2:0] ch;
    } xfer_t;

    typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_UPDATE} state_t;

endpackage

// File: hw/reload_mem.sv
// Reload register sets, one frame and count reload word per channel
`timescale 1ns/1ns
module reload_mem (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Write port
    input wire logic i_we,
    input wire logic [2:0] i_waddr,
    input dma_pkg::reload_t i_wdata,
    // Read port, one cycle latency
    input wire logic [2:0] i_raddr,
    output dma_pkg::reload_t o_rdata
);
    import dma_pkg::*;

    reload_t mem_q [NCH];
    reload_t rdata_q;

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            for (int i = 0; i < NCH; i++)
                mem_q[i] <= '0;
        end
        else if (i_we)
            mem_q[i_waddr] <= i_wdata;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
            rdata_q <= '0;
        else
            rdata_q <= mem_q[i_raddr];
    end

    assign o_rdata = rdata_q;

endmodule

// File: hw/rr_arbiter.sv
// Two-level round-robin channel arbiter
`timescale 1ns/1ns
module rr_arbiter (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Requests
    input wire logic [dma_pkg::NCH-1:0] i_req,
    input wire logic [dma_pkg::NCH-1:0] i_hi,
    input wire logic i_advance,
    // Grant
    output logic o_valid,
    output logic [2:0] o_grant
);
    import dma_pkg::*;

    logic [2:0] hi_ptr_q;
    logic [2:0] lo_ptr_q;
    logic hv;
    logic lv;
    logic [2:0] hg;
    logic [2:0] lg;

    // First requester after the last one served
    function automatic logic [3:0] pick(input logic [NCH-1:0] req,
                                        input logic [2:0] ptr);
        logic [3:0] r;
        int j;
        r = 4'h0;
        j = 0;
        for (int k = NCH; k >= 1; k--)
        begin
            j = (int'(ptr) + k) % NCH;
            if (req[j])
                r = {1'b1, 3'(j)};
        end
        return r;
    endfunction

    assign {hv, hg} = pick(i_req & i_hi, hi_ptr_q);
    assign {lv, lg} = pick(i_req & ~i_hi, lo_ptr_q);
    assign o_valid = hv | lv;
    assign o_grant = hv ? hg : lg;

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            hi_ptr_q <= RST_PTR;
            lo_ptr_q <= RST_PTR;
        end
        else if (i_advance)
        begin
            if (hv)
                hi_ptr_q <= hg;
            else if (lv)
                lo_ptr_q <= lg;
        end
    end

endmodule

// File: hw/dma_channel_transfer_control.sv
// Six-channel DMA transfer control: counting, indexing, sync, interrupts
// Notes on behaviour
// - 8-bit frame counter per channel
// - frame counter drops on frame's last transfer
// - auto reinit reloads frame count at block end
// - frame count zero means one frame
// - 16-bit element counter, drops per element
// - auto reinit reloads element count at block end
// - doubleword makes two transfers, addresses updated twice
// - doubleword pair counts as one element
// - index selects pick step register pair
// - element step added except on frame's last
// - frame step applied on frame's last transfer
// - interrupt enable low means no interrupt
// - auto buffer interrupts at full, optionally half
// - multiframe interrupts at block or every frame
// - 4-bit sync select, serial and uart events
// - codes D-F timers and external interrupt three
// - six channel interrupts, 0-3 share cpu lines
// - mux select resets to serial interrupts; here the select is an input with no reset, and reset clears o_cpu_irq
// - mux codes route channels 2-3 or 0-3
// - per channel reload select picks reload set
// - equal priority channels served round robin
// - each address const, inc, dec or indexed
`timescale 1ns/1ns
module dma_channel_transfer_control (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Channel setup
    input dma_pkg::chan_cfg_t [dma_pkg::NCH-1:0] i_cfg,
    input dma_pkg::chan_load_t [dma_pkg::NCH-1:0] i_load,
    input wire logic [dma_pkg::NCH-1:0] i_start,
    // Global step and selection controls
    input wire logic [15:0] i_element_step_a,
    input wire logic [15:0] i_element_step_b,
    input wire logic [15:0] i_frame_step_a,
    input wire logic [15:0] i_frame_step_b,
    input wire logic i_per_channel_reload_select,
    input wire logic [1:0] i_irq_line_mux_select,
    // Reload register writes
    input wire logic i_reload_we,
    input wire logic [2:0] i_reload_idx,
    input dma_pkg::reload_t i_reload_data,
    // Events and shared interrupt sources
    input wire logic [dma_pkg::NEV-1:0] i_sync_events,
    input wire logic [dma_pkg::NCPU-1:0] i_serial_irq,
    // Transfer request
    input wire logic i_xfer_ready,
    output logic o_xfer_valid,
    output dma_pkg::xfer_t o_xfer,
    // Status and interrupts
    output logic [dma_pkg::NCH-1:0] o_active,
    output logic [dma_pkg::NCH-1:0] o_chan_irq,
    output logic [dma_pkg::NCPU-1:0] o_cpu_irq
);
    import dma_pkg::*;

    state_t state_q;
    logic [2:0] cur_ch_q;
    logic half_q;
    logic xfer_valid_q;
    xfer_t xfer_q;
    logic [7:0] frm_q [NCH];
    logic [15:0] elem_q [NCH];
    logic [15:0] src_q [NCH];
    logic [15:0] dst_q [NCH];
    logic [NCH-1:0] active_q;
    logic [NCH-1:0] pend_q;
    logic [NCH-1:0] chan_irq_q;
    logic [NCPU-1:0] cpu_irq_q;

    logic [NCH-1:0] req;
    logic [NCH-1:0] hi;
    logic [NCH-1:0] hit;
    logic arb_valid;
    logic [2:0] grant;
    logic [2:0] rl_idx;
    reload_t rl;

    chan_cfg_t cc;
    logic [15:0] cur_src;
    logic [15:0] cur_dst;
    logic [15:0] cur_elem;
    logic [7:0] cur_frm;
    logic upd;
    logic no_load;
    logic last_xfer;
    logic frame_last;
    logic blk_last;
    logic reinit;
    logic stop;
    logic chan_irq;
    logic [15:0] src_step;
    logic [15:0] dst_step;
    logic [15:0] src_nx;
    logic [15:0] dst_nx;
    logic [15:0] elem_nx;
    logic [7:0] frm_nx;
    logic [NCH-1:0] irq_d;

    function automatic logic sync_hit(input logic [3:0] sel,
                                      input logic [NEV-1:0] ev);
        logic h;
        h = 1'b0;
        case (sel)
            SYNC_NONE: h = 1'b0;
            SYNC_TMR0: h = ev[EV_TMR0];
            SYNC_EXT3: h = ev[EV_EXT3];
            SYNC_TMR1: h = ev[EV_TMR1];
            default:
            begin
                if (sel <= SYNC_UART)
                    h = ev[sel - 4'h1];
            end
        endcase
        return h;
    endfunction

    // step register pair chosen by select bit
    function automatic logic [15:0] pick_step(input logic sel,
                                              input logic last,
                                              input logic [15:0] ea,
                                              input logic [15:0] eb,
                                              input logic [15:0] fa,
                                              input logic [15:0] fb);
        if (last)
            return sel ? fb : fa;
        return sel ? eb : ea;
    endfunction

    function automatic logic [15:0] next_addr(input logic [15:0] a,
                                              input logic [1:0] mode,
                                              input logic [15:0] step);
        logic [15:0] n;
        n = a;
        case (mode)
            AM_CONST: n = a;
            AM_INC: n = a + 16'h0001;
            AM_DEC: n = a - 16'h0001;
            default: n = a + step;
        endcase
        return n;
    endfunction

    // pending event gates each element request, unless the sync select is SYNC_NONE
    generate
        for (genvar g = 0; g < NCH; g++)
        begin : g_chan
            assign hit[g] = sync_hit(i_cfg[g].sync_event_select,
                                     i_sync_events);
            assign hi[g] = i_cfg[g].hi_prio;
            assign req[g] = active_q[g] & (pend_q[g] |
                (i_cfg[g].sync_event_select == SYNC_NONE));
        end
    endgenerate

    rr_arbiter u_arb (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_req(req),
        .i_hi(hi),
        .i_advance(state_q == S_IDLE),
        .o_valid(arb_valid),
        .o_grant(grant)
    );

    // own reload set or channel zero's
    assign rl_idx = i_per_channel_reload_select ? cur_ch_q : RELOAD_SET0;

    reload_mem u_rl (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_we(i_reload_we),
        .i_waddr(i_reload_idx),
        .i_wdata(i_reload_data),
        .i_raddr(rl_idx),
        .o_rdata(rl)
    );

    assign cc = i_cfg[cur_ch_q];
    assign cur_src = src_q[cur_ch_q];
    assign cur_dst = dst_q[cur_ch_q];
    assign cur_elem = elem_q[cur_ch_q];
    assign cur_frm = frm_q[cur_ch_q];
    assign upd = (state_q == S_UPDATE);
    assign no_load = !i_start[cur_ch_q];
    // pair counts once, on its second half
    assign last_xfer = !cc.dword || half_q;
    assign frame_last = (cur_elem == RST_ELEM) && last_xfer;
    // zero frame count is the final frame
    assign blk_last = frame_last && (cur_frm == RST_FRAME);
    assign reinit = cc.auto_reinit_enable || cc.auto_buffer_mode;
    assign stop = blk_last && !reinit;

    // frame step on a frame's last transfer
    assign src_step = pick_step(cc.source_index_select, frame_last,
        i_element_step_a, i_element_step_b, i_frame_step_a, i_frame_step_b);
    assign dst_step = pick_step(cc.dest_index_select, frame_last,
        i_element_step_a, i_element_step_b, i_frame_step_a, i_frame_step_b);
    assign src_nx = next_addr(cur_src, cc.src_mode, src_step);
    assign dst_nx = next_addr(cur_dst, cc.dst_mode, dst_step);

    // element count drops after each element
    // element count reloaded after every frame, unless the block stops
    always_comb
    begin
        elem_nx = cur_elem;
        if (!last_xfer)
            elem_nx = cur_elem;
        else if (cur_elem != RST_ELEM)
            elem_nx = cur_elem - 16'h0001;
        else if (!blk_last || reinit)
            elem_nx = rl.count;
        else
            elem_nx = RST_ELEM;
    end

    // frame count drops on a frame's last transfer
    // frame count reloaded at block end when reinit is set
    always_comb
    begin
        frm_nx = cur_frm;
        if (frame_last && !blk_last)
            frm_nx = cur_frm - 8'h01;
        else if (blk_last && reinit)
            frm_nx = rl.frame;
    end

    // enable bit low silences the channel
    // auto buffer full, plus half when timing set
    // multiframe block end, or every frame end
    always_comb
    begin
        chan_irq = 1'b0;
        if (!cc.irq_enable_bit)
            chan_irq = 1'b0;
        else if (cc.auto_buffer_mode)
            chan_irq = blk_last || (cc.irq_timing_select && last_xfer &&
                (cur_elem != RST_ELEM) &&
                ((cur_elem - 16'h0001) == {1'b0, rl.count[15:1]}));
        else if (cc.irq_timing_select)
            chan_irq = frame_last;
        else
            chan_irq = blk_last;
        irq_d = (upd && chan_irq) ? NCH'(6'h01 << cur_ch_q) : '0;
    end

    // Sequencing of one element, two halves in doubleword mode
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            state_q <= S_IDLE;
            cur_ch_q <= 3'h0;
            half_q <= 1'b0;
            xfer_valid_q <= 1'b0;
            xfer_q <= '0;
        end
        else
        begin
            case (state_q)
                S_IDLE:
                begin
                    if (arb_valid)
                    begin
                        cur_ch_q <= grant;
                        half_q <= 1'b0;
                        xfer_valid_q <= 1'b1;
                        xfer_q <= '{src: src_q[grant], dst: dst_q[grant],
                                    ch: grant};
                        state_q <= S_ISSUE;
                    end
                end
                S_ISSUE:
                begin
                    if (i_xfer_ready)
                    begin
                        xfer_valid_q <= 1'b0;
                        state_q <= S_UPDATE;
                    end
                end
                S_UPDATE:
                begin
                    // second half follows back to back
                    if (cc.dword && !half_q)
                    begin
                        half_q <= 1'b1;
                        xfer_valid_q <= 1'b1;
                        xfer_q <= '{src: src_nx, dst: dst_nx, ch: cur_ch_q};
                        state_q <= S_ISSUE;
                    end
                    else
                        state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Addresses; a start overrides any update in flight
    always_ff @(posedge i_clk)
    begin
        for (int i = 0; i < NCH; i++)
        begin
            if (!i_rstn)
            begin
                src_q[i] <= RST_ADDR;
                dst_q[i] <= RST_ADDR;
            end
            else if (i_start[i])
            begin
                src_q[i] <= i_load[i].src;
                dst_q[i] <= i_load[i].dst;
            end
            else if (upd && cur_ch_q == 3'(i))
            begin
                src_q[i] <= src_nx;
                dst_q[i] <= dst_nx;
            end
        end
    end

    // Element and frame counters
    always_ff @(posedge i_clk)
    begin
        for (int i = 0; i < NCH; i++)
        begin
            if (!i_rstn)
            begin
                elem_q[i] <= RST_ELEM;
                frm_q[i] <= RST_FRAME;
            end
            else if (i_start[i])
            begin
                elem_q[i] <= i_load[i].elem;
                frm_q[i] <= i_load[i].frame;
            end
            else if (upd && cur_ch_q == 3'(i))
            begin
                elem_q[i] <= elem_nx;
                frm_q[i] <= frm_nx;
            end
        end
    end

    // Run state and sync pending; a new event beats the clear
    always_ff @(posedge i_clk)
    begin
        for (int i = 0; i < NCH; i++)
        begin
            if (!i_rstn)
            begin
                active_q[i] <= 1'b0;
                pend_q[i] <= 1'b0;
            end
            else
            begin
                // stop at block end without reinit
                if (i_start[i])
                    active_q[i] <= 1'b1;
                else if (upd && stop && cur_ch_q == 3'(i))
                    active_q[i] <= 1'b0;
                pend_q[i] <= hit[i] | (pend_q[i] & ~(state_q == S_IDLE &&
                    arb_valid && grant == 3'(i)));
            end
        end
    end

    // channel interrupts, 0 to 3 on shared lines
    // code 00b and the reserved code keep serial
    // 01b brings in channels 2-3, 10b all four
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            chan_irq_q <= '0;
            cpu_irq_q <= '0;
        end
        else
        begin
            chan_irq_q <= irq_d;
            case (i_irq_line_mux_select)
                MUX_CH23: cpu_irq_q <= {irq_d[3:2], i_serial_irq[1:0]};
                MUX_ALL: cpu_irq_q <= irq_d[3:0];
                default: cpu_irq_q <= i_serial_irq;
            endcase
        end
    end

    assign o_xfer_valid = xfer_valid_q;
    assign o_xfer = xfer_q;
    assign o_active = active_q;
    assign o_chan_irq = chan_irq_q;
    assign o_cpu_irq = cpu_irq_q;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    sequence mid_upd;
        upd && !frame_last && no_load;
    endsequence

    sequence end_upd;
        upd && frame_last && no_load;
    endsequence

    elem_step_a: assert property (mid_upd ##0 cc.src_mode == AM_INDEX
        |=> cur_src == $past(cur_src) + $past(src_step))
        else $error("element step not applied");
    frame_step_a: assert property (end_upd ##0 cc.dst_mode == AM_INDEX
        |=> cur_dst == $past(cur_dst) + $past(dst_step))
        else $error("frame step not applied");
    frame_dec_a: assert property (end_upd ##0 cur_frm != RST_FRAME
        |=> cur_frm == $past(cur_frm) - 8'h01)
        else $error("frame count not decremented");
    frame_reload_a: assert property (end_upd ##0 blk_last && reinit
        |=> cur_frm == $past(rl.frame))
        else $error("frame count not reloaded");
    elem_reload_a: assert property (end_upd ##0 blk_last && reinit
        |=> cur_elem == $past(rl.count))
        else $error("element count not reloaded");
    dword_pair_a: assert property (upd && cc.dword && !half_q
        |=> o_xfer_valid && o_xfer.src == $past(src_nx))
        else $error("second doubleword half missing");
    dword_count_a: assert property (upd && cc.dword && !half_q && no_load
        |=> cur_elem == $past(cur_elem))
        else $error("doubleword half counted");
    irq_off_a: assert property (upd && !cc.irq_enable_bit
        |=> o_chan_irq == '0)
        else $error("interrupt while disabled");
    mux_serial_a: assert property (i_irq_line_mux_select == MUX_SERIAL
        |=> o_cpu_irq == $past(i_serial_irq))
        else $error("serial interrupts not routed");
    mux_all_a: assert property (i_irq_line_mux_select == MUX_ALL
        |=> o_cpu_irq == $past(irq_d[3:0]))
        else $error("channel interrupts not routed");
    block_stop_a: assert property (end_upd ##0 stop
        |=> !o_active[$past(cur_ch_q)] ##1
        !(o_xfer_valid && o_xfer.ch == $past(cur_ch_q, 2)))
        else $error("channel kept running");
    sync_wait_a: assert property (state_q == S_IDLE && arb_valid &&
        i_cfg[grant].sync_event_select != SYNC_NONE |-> pend_q[grant])
        else $error("synced channel ran without event");

endmodule

// File: tb/mem_model.sv
// Memory side model: accepts each transfer after a set wait
`timescale 1ns/1ns
module mem_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Transfer handshake
    input wire logic i_valid,
    input wire logic [1:0] i_wait,
    output logic o_ready
);
    logic [1:0] cnt_q;
    // Ready drops after every acceptance, so one transfer at a time
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || !i_valid || o_ready)
        begin
            cnt_q <= 2'h0;
            o_ready <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_q + 2'h1;
            o_ready <= (cnt_q >= i_wait);
        end
    end
endmodule

// File: tb/tb.sv
// Testbench for the DMA transfer control block
`timescale 1ns/1ns
module tb;
    import dma_pkg::*;
    logic i_clk, i_rstn, prs, rwe, ready, valid;
    chan_cfg_t [NCH-1:0] cfg;
    chan_load_t [NCH-1:0] load;
    chan_cfg_t c;
    logic [NCH-1:0] start, act, cirq;
    logic [15:0] esa, esb, fsa, fsb;
    logic [1:0] mux, wait_n;
    logic [2:0] ridx;
    reload_t rdata;
    logic [NEV-1:0] ev;
    logic [NCPU-1:0] sirq, cpu;
    xfer_t xf;
    int error_cnt, comparisons, irq0, irq1, cpu0, irq3, cpu3;

    dma_channel_transfer_control dut (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_cfg(cfg), .i_load(load), .i_start(start),
        .i_element_step_a(esa), .i_element_step_b(esb),
        .i_frame_step_a(fsa), .i_frame_step_b(fsb),
        .i_per_channel_reload_select(prs), .i_irq_line_mux_select(mux),
        .i_reload_we(rwe), .i_reload_idx(ridx), .i_reload_data(rdata),
        .i_sync_events(ev), .i_serial_irq(sirq), .i_xfer_ready(ready),
        .o_xfer_valid(valid), .o_xfer(xf), .o_active(act),
        .o_chan_irq(cirq), .o_cpu_irq(cpu));
    mem_model mem (.i_clk(i_clk), .i_rstn(i_rstn), .i_valid(valid),
        .i_wait(wait_n), .o_ready(ready));

    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    always @(posedge i_clk)
    begin
        if (cirq[0] === 1'b1) irq0++;
        if (cirq[1] === 1'b1) irq1++;
        if (cpu[0] === 1'b1) cpu0++;
        if (cirq[3] === 1'b1) irq3++;
        // Line 3 carries serial traffic until the mux picks channels
        if (cpu[3] === 1'b1 && mux == MUX_CH23) cpu3++;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // Load lands two edges before the start pulse samples it
    task automatic go(input int ch, input chan_load_t l);
        @(posedge i_clk);
        cfg[ch] <= c;
        load[ch] <= l;
        @(posedge i_clk);
        start[ch] <= 1'b1;
        @(posedge i_clk);
        start[ch] <= 1'b0;
    endtask

    task automatic xfer(input logic [15:0] s, d, input logic [2:0] ch);
        int n;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (!(valid === 1'b1 && ready === 1'b1) && n < 100);
        // A transfer that never comes is a failure, not a stale match
        if (!(valid === 1'b1 && ready === 1'b1))
        begin
            error_cnt++;
            stop_test;
        end
        else
            check(xf, {s, d, ch});
    endtask

    task automatic stop_test;
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #40000;
        error_cnt++;
        stop_test;
    end

    initial
    begin
        i_rstn = 1'b0; cfg = '0; load = '0; start = '0; prs = 1'b0;
        esa = 16'h0001; esb = 16'h0003; fsa = 16'h0040; fsb = 16'h0020;
        mux = 2'h0; rwe = 1'b0; ridx = 3'h0; rdata = '0; ev = '0;
        sirq = 4'hA; wait_n = 2'h0;
        tick(5);
        i_rstn <= 1'b1;
        tick(3);
        check(act, 0);
        check(cpu, 4'hA);
        rwe <= 1'b1;
        rdata <= '{8'h00, 16'h0002};
        tick(1);
        rwe <= 1'b0;
        mux <= MUX_ALL;
        c = '0;
        c.irq_enable_bit = 1'b1;
        c.irq_timing_select = 1'b1;
        c.dest_index_select = 1'b1;
        c.src_mode = AM_INC;
        c.dst_mode = AM_INDEX;
        go(0, '{16'h0100, 16'h0200, 16'h0002, 8'h01});
        // Frame two element count comes from reload set zero
        for (int f = 0; f < 2; f++)
            for (int e = 0; e < 3; e++)
                xfer(16'h0100 + 3 * f + e, 16'h0200 + 16'h26 * f + 3 * e, 0);
        tick(5);
        check(irq0, 2);
        check(cpu0, 2);
        check(act[0], 0);
        c = '0;
        c.dword = 1'b1;
        c.irq_timing_select = 1'b1;
        c.src_mode = AM_INC;
        wait_n <= 2'h2;
        go(1, '{16'h0300, 16'h0400, 16'h0000, 8'h00});
        xfer(16'h0300, 16'h0400, 1);
        xfer(16'h0301, 16'h0400, 1);
        tick(8);
        check(act[1], 0);
        check(irq1, 0);
        c = '0;
        c.sync_event_select = SYNC_TMR0;
        wait_n <= 2'h0;
        go(2, '{16'h0500, 16'h0600, 16'h0000, 8'h00});
        ev[EV_TMR1] <= 1'b1;
        tick(1);
        ev <= '0;
        tick(8);
        check(valid, 0);
        check(act[2], 1);
        ev[EV_TMR0] <= 1'b1;
        tick(1);
        ev <= '0;
        xfer(16'h0500, 16'h0600, 2);
        tick(6);
        check(act[2], 0);
        // Auto buffer on channel 3 with its own reload set
        prs <= 1'b1;
        mux <= MUX_CH23;
        rwe <= 1'b1;
        ridx <= 3'h3;
        rdata <= '{8'h00, 16'h0003};
        tick(1);
        rwe <= 1'b0;
        c = '0;
        c.auto_buffer_mode = 1'b1;
        c.irq_enable_bit = 1'b1;
        c.irq_timing_select = 1'b1;
        c.sync_event_select = SYNC_EXT3;
        c.src_mode = AM_INC;
        c.dst_mode = AM_DEC;
        go(3, '{16'h0700, 16'h0800, 16'h0003, 8'h00});
        // Fifth element runs on the reloaded count of set 3
        for (int e = 0; e < 5; e++)
        begin
            ev[EV_EXT3] <= 1'b1;
            tick(1);
            ev <= '0;
            xfer(16'h0700 + e, 16'h0800 - e, 3);
        end
        tick(5);
        // Set 0 would put a second half-buffer interrupt here
        check(irq3, 2);
        check(cpu3, 2);
        check(cpu[1:0], 2'b10);
        check(act[3], 1);
        // Channels 5 and 0 on one event: rotation starts after 3
        c = '0;
        c.sync_event_select = 4'h1;
        c.src_mode = AM_INC;
        go(0, '{16'h0C00, 16'h0D00, 16'h0000, 8'h00});
        go(5, '{16'h0E00, 16'h0F00, 16'h0000, 8'h00});
        ev[0] <= 1'b1;
        tick(1);
        ev <= '0;
        xfer(16'h0E00, 16'h0F00, 5);
        xfer(16'h0C00, 16'h0D00, 0);
        tick(6);
        check(act, 6'h08);
        stop_test;
    end
endmodule
